/* hw/eewr_host.sv */
/*
 * Host controller that loads bytes/pages into a parallel EEPROM and
 * detects end of internal write by toggle-bit polling or timeout.
 * Assumes the memory pins are registered straight to pads; data pins
 * are split into in/out/enable and resolved outside.
 */
// ****************************************
// Host controller
// ****************************************
module eewr_host #(
	parameter int WRITE_TIMEOUT = eewr_pkg::WRITE_CYCLES
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// Request side
	input  wire logic        REQ_VALID,
	input  wire logic        REQ_WRITE,
	input  wire logic        REQ_LAST,
	input  wire logic [12:0] REQ_ADDR,
	input  wire logic [7:0]  REQ_WDATA,
	output logic             REQ_READY,
	output logic             RSP_VALID,
	output logic [7:0]       RSP_RDATA,
	output logic             BUSY,
	output logic             TIMEOUT,
	// Memory pins
	output logic             CE_N,
	output logic             OE_N,
	output logic             WE_N,
	output logic [12:0]      ADDR,
	output logic [7:0]       DQ_OUT,
	output logic             DQ_OE,
	input  wire logic [7:0]  DQ_IN
);
	typedef enum logic [6:0] {
		S_IDLE  = 7'b000_0001,
		S_WSTB  = 7'b000_0010,
		S_WREC  = 7'b000_0100,
		S_LOAD  = 7'b000_1000,
		S_POLL  = 7'b001_0000,
		S_PGAP  = 7'b010_0000,
		S_READ  = 7'b100_0000
	} eewr_state_t;

	typedef struct packed {
		eewr_state_t state;
		logic [17:0] cnt;
		logic [17:0] gap;
		logic [22:0] wait_cnt;
		logic [6:0]  page;
		logic        have_prev;
		logic        prev_tog;
		logic [7:0]  dq_s1;
		logic [7:0]  dq_s2;
		logic        req_ready;
		logic        rsp_valid;
		logic [7:0]  rsp_rdata;
		logic        busy;
		logic        timeout;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic [12:0] addr;
		logic [7:0]  dq_out;
		logic        dq_oe;
	} eewr_reg_t;

	eewr_reg_t r;
	eewr_reg_t next_r;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_r = r;
		next_r.dq_s1 = DQ_IN;
		next_r.dq_s2 = r.dq_s1;
		next_r.rsp_valid = 1'b0;
		next_r.timeout = 1'b0;
		case (r.state)
			S_IDLE, S_LOAD: begin
				next_r.req_ready = 1'b1;
				if (r.state == S_LOAD)
					next_r.gap = r.gap + 18'h0_0001;
				if (r.req_ready && REQ_VALID && REQ_WRITE) begin
					next_r.req_ready = 1'b0;
					next_r.ce_n = 1'b0;
					next_r.oe_n = 1'b1;
					next_r.we_n = 1'b0;
					// Page bits held from first byte of page
					next_r.addr = (r.state == S_LOAD) ?
						{r.page, REQ_ADDR[5:0]} : REQ_ADDR;
					next_r.page = (r.state == S_LOAD) ?
						r.page : REQ_ADDR[12:6];
					next_r.dq_out = REQ_WDATA;
					next_r.dq_oe = 1'b1;
					next_r.have_prev = REQ_LAST;
					next_r.cnt = '0;
					next_r.state = S_WSTB;
				end else if (r.req_ready && REQ_VALID && r.state == S_IDLE) begin
					next_r.req_ready = 1'b0;
					next_r.ce_n = 1'b0;
					next_r.oe_n = 1'b0;
					next_r.addr = REQ_ADDR;
					next_r.cnt = '0;
					next_r.state = S_READ;
				end else if (r.state == S_LOAD &&
					r.gap >= 18'(eewr_pkg::BYTE_LOAD_CYCLES / 2)) begin
					// No load for BYTE_LOAD_CYCLES / 2 cycles: start completion wait
					next_r.req_ready = 1'b0;
					next_r.busy = 1'b1;
					next_r.wait_cnt = '0;
					next_r.have_prev = 1'b0;
					next_r.cnt = '0;
					next_r.state = S_PGAP;
				end
			end
			S_WSTB: begin
				next_r.cnt = r.cnt + 18'h0_0001;
				if (r.cnt + 18'h0_0001 >= 18'(eewr_pkg::STROBE_CYCLES)) begin
					next_r.we_n = 1'b1;
					next_r.ce_n = 1'b1;
					next_r.cnt = '0;
					next_r.state = S_WREC;
				end
			end
			S_WREC: begin
				next_r.cnt = r.cnt + 18'h0_0001;
				next_r.dq_oe = 1'b0;
				if (r.cnt + 18'h0_0001 >= 18'(eewr_pkg::RECOVERY_CYCLES)) begin
					next_r.gap = '0;
					next_r.cnt = '0;
					if (r.have_prev) begin
						next_r.busy = 1'b1;
						next_r.wait_cnt = '0;
						next_r.have_prev = 1'b0;
						next_r.state = S_PGAP;
					end else begin
						next_r.req_ready = 1'b1;
						next_r.state = S_LOAD;
					end
				end
			end
			S_PGAP: begin
				// Idle between polls, bounded by the full write time
				next_r.wait_cnt = r.wait_cnt + 23'h00_0001;
				next_r.cnt = r.cnt + 18'h0_0001;
				if (r.wait_cnt + 23'h00_0001 >= 23'(WRITE_TIMEOUT)) begin
					next_r.busy = 1'b0;
					next_r.timeout = 1'b1;
					next_r.state = S_IDLE;
				end else if (r.cnt + 18'h0_0001 >= 18'(eewr_pkg::RECOVERY_CYCLES)) begin
					next_r.ce_n = 1'b0;
					next_r.oe_n = 1'b0;
					next_r.cnt = '0;
					next_r.state = S_POLL;
				end
			end
			S_POLL, S_READ: begin
				next_r.cnt = r.cnt + 18'h0_0001;
				if (r.state == S_POLL)
					next_r.wait_cnt = r.wait_cnt + 23'h00_0001;
				if (r.cnt + 18'h0_0001 >= 18'(eewr_pkg::READ_CYCLES + 2)) begin
					next_r.ce_n = 1'b1;
					next_r.oe_n = 1'b1;
					next_r.cnt = '0;
					if (r.state == S_READ) begin
						next_r.rsp_valid = 1'b1;
						next_r.rsp_rdata = r.dq_s2;
						next_r.state = S_IDLE;
					end else begin
						// Only an unchanged toggle bit between two polls counts as done
						next_r.prev_tog = r.dq_s2[eewr_pkg::TOGGLE_BIT];
						next_r.have_prev = 1'b1;
						next_r.state = S_PGAP;
						if (r.have_prev && r.prev_tog ==
							r.dq_s2[eewr_pkg::TOGGLE_BIT]) begin
							next_r.busy = 1'b0;
							next_r.state = S_IDLE;
						end
					end
				end
			end
			default: next_r.state = S_IDLE;
		endcase
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			r <= '0;
			r.state <= S_IDLE;
			r.ce_n <= 1'b1;
			r.oe_n <= 1'b1;
			r.we_n <= 1'b1;
			r.addr <= eewr_pkg::ADDR_RST;
			r.dq_out <= eewr_pkg::DATA_RST;
		end else begin
			r <= next_r;
		end
	end

	assign REQ_READY = r.req_ready;
	assign RSP_VALID = r.rsp_valid;
	assign RSP_RDATA = r.rsp_rdata;
	assign BUSY      = r.busy;
	assign TIMEOUT   = r.timeout;
	assign CE_N      = r.ce_n;
	assign OE_N      = r.oe_n;
	assign WE_N      = r.we_n;
	assign ADDR      = r.addr;
	assign DQ_OUT    = r.dq_out;
	assign DQ_OE     = r.dq_oe;

	// ****************************************
	// Checks
	// ****************************************
	property p_write_pins;
		@(posedge CLK) disable iff (RST)
		!r.we_n |-> (!r.ce_n && r.oe_n && r.dq_oe);
	endproperty
	a_write_pins: assert property (p_write_pins)
		else $error("write strobe without proper pin state");

	property p_strobe_width;
		@(posedge CLK) disable iff (RST)
		$fell(r.we_n) |-> !r.we_n ##1 r.we_n;
	endproperty
	a_strobe_width: assert property (p_strobe_width)
		else $error("write strobe width wrong");

	property p_no_access_busy;
		@(posedge CLK) disable iff (RST)
		r.busy |-> r.we_n;
	endproperty
	a_no_access_busy: assert property (p_no_access_busy)
		else $error("write during internal write");

	property p_page_fixed;
		@(posedge CLK) disable iff (RST)
		($fell(r.we_n) && r.state == S_WSTB && $past(r.state) == S_LOAD)
			|-> r.addr[12:6] == r.page;
	endproperty
	a_page_fixed: assert property (p_page_fixed)
		else $error("page bits moved inside page");

	property p_poll_read;
		@(posedge CLK) disable iff (RST)
		(r.state == S_POLL && $past(r.state) == S_PGAP)
			|-> (!r.oe_n && !r.ce_n && r.we_n && !r.dq_oe) [*4];
	endproperty
	a_poll_read: assert property (p_poll_read)
		else $error("poll not an ordinary read");

	property p_done_needs_two;
		@(posedge CLK) disable iff (RST)
		($fell(r.busy) && !r.timeout) |-> $past(r.have_prev);
	endproperty
	a_done_needs_two: assert property (p_done_needs_two)
		else $error("completion from a single poll");

	property p_rsp_after_read;
		@(posedge CLK) disable iff (RST)
		r.rsp_valid |-> $past(r.state == S_READ);
	endproperty
	a_rsp_after_read: assert property (p_rsp_after_read)
		else $error("response without read");

	property p_timeout_clears;
		@(posedge CLK) disable iff (RST)
		r.timeout |-> !r.busy && r.state == S_IDLE;
	endproperty
	a_timeout_clears: assert property (p_timeout_clears)
		else $error("timeout left busy");

	c_write: cover property (@(posedge CLK) disable iff (RST)
		$fell(r.we_n));
	c_poll_done: cover property (@(posedge CLK) disable iff (RST)
		$fell(r.busy) && !r.timeout);
	c_timeout: cover property (@(posedge CLK) disable iff (RST)
		r.timeout);
	c_read: cover property (@(posedge CLK) disable iff (RST) r.rsp_valid);
endmodule : eewr_host

/* hw/eewr_pkg.sv */
/*
 * Constants for the parallel EEPROM write/poll host controller.
 * Assumes a 20 MHz system clock and an 8K x 8 byte-wide memory.
 */
package eewr_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS      = 50;
	localparam int WRITE_DURATION_MS  = 5;
	localparam int WRITE_TYPICAL_MS   = 2;
	localparam int WRITE_CYCLES       =
		(WRITE_DURATION_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_NS          = 50;
	localparam int STROBE_CYCLES      =
		(STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVERY_NS        = 50;
	localparam int RECOVERY_CYCLES    =
		(RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_ACCESS_NS     = 120;
	localparam int READ_CYCLES        =
		(READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	// Byte load interval upper limit, rounded down
	localparam int BYTE_LOAD_US       = 100;
	localparam int BYTE_LOAD_CYCLES   =
		(BYTE_LOAD_US * 1000) / CLK_PERIOD_NS;
	// ****************************************
	// Layout
	// ****************************************
	localparam int ADDR_W             = 13;
	localparam int PAGE_LSB           = 6;
	localparam int TOGGLE_BIT         = 6;
	localparam int CNT_W              = 18;
	localparam logic [12:0] ADDR_RST  = 13'h0000;
	localparam logic [7:0]  DATA_RST  = 8'h00;
endpackage : eewr_pkg

/* tb/eewr_host_tb_top.sv */
/*
 * Self-checking bench for the EEPROM write/poll host controller.
 * Assumes the behavioural memory model beside it.
 */
module eewr_host_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WT = 400;
	logic        CLK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0;
	logic        REQ_WRITE = 1'b0, REQ_LAST = 1'b0;
	logic [12:0] REQ_ADDR  = 13'h0000;
	logic [7:0]  REQ_WDATA = 8'h00;
	logic        REQ_READY, RSP_VALID, BUSY, TIMEOUT;
	logic        CE_N, OE_N, WE_N, DQ_OE;
	logic [12:0] ADDR;
	logic [7:0]  RSP_RDATA, DQ_OUT, DQ_IN;
	int          fails = 0, n_checks = 0;
	always #25 CLK = ~CLK;
	eewr_host #(.WRITE_TIMEOUT(WT)) i_dut (.CLK(CLK), .RST(RST),
		.REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_LAST(REQ_LAST),
		.REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY),
		.RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .BUSY(BUSY),
		.TIMEOUT(TIMEOUT), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N),
		.ADDR(ADDR), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .DQ_IN(DQ_IN));
	eewr_mem_model i_mem (.CLK(CLK), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N),
		.ADDR(ADDR), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .DQ_IN(DQ_IN));
	task automatic final_report;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic chk8(input string nm, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk8
	task automatic chk1(input string nm, input logic e, g);
		chk8(nm, {7'h00, e}, {7'h00, g});
	endtask : chk1
	task automatic stuck(input string nm);
		fails++;
		$display("[FAIL] %s exp done got hang", nm);
		final_report();
	endtask : stuck
	task automatic req(input logic w, l, input logic [12:0] a,
		input logic [7:0] d);
		int i;
		@(posedge CLK);
		#5;
		{REQ_VALID, REQ_WRITE, REQ_LAST, REQ_ADDR, REQ_WDATA} = {1'b1, w, l, a, d};
		for (i = 0; i < 2000; i++) begin
			@(posedge CLK);
			if (REQ_READY === 1'b1)
				break;
		end
		if (i == 2000)
			stuck("ready");
		#5 REQ_VALID = 1'b0;
	endtask : req
	task automatic rd(input logic [12:0] a, input logic [7:0] e);
		int i;
		req(1'b0, 1'b0, a, 8'h00);
		for (i = 0; i < 20 && RSP_VALID !== 1'b1; i++)
			@(posedge CLK);
		if (i == 20)
			stuck("read");
		chk8("read data", e, RSP_RDATA);
	endtask : rd
	task automatic wait_done(input logic exp_to);
		int i;
		logic to_seen;
		to_seen = 1'b0;
		for (i = 0; i < 50 && BUSY !== 1'b1; i++)
			@(posedge CLK);
		if (i == 50)
			stuck("busy rise");
		for (i = 0; i < WT + 50 && BUSY !== 1'b0; i++) begin
			@(posedge CLK);
			to_seen |= (TIMEOUT === 1'b1);
		end
		@(posedge CLK);
		to_seen |= (TIMEOUT === 1'b1);
		if (i == WT + 50)
			stuck("busy");
		chk1("timeout", exp_to, to_seen);
	endtask : wait_done
	initial begin
		logic [7:0]  d [4];
		logic [12:0] a;
		void'($urandom(32'he1335ee6));
		repeat (6) @(posedge CLK);
		chk1("ready in reset", 1'b0, REQ_READY);
		chk1("select in reset", 1'b1, CE_N);
		#5 RST = 1'b0;
		// Single bytes, top address first
		for (int k = 0; k < 4; k++) begin
			a = (k == 0) ? 13'h1fff : 13'($urandom);
			d[0] = 8'($urandom);
			req(1'b1, 1'b1, a, d[0]);
			wait_done(1'b0);
			chk1("memory idle", 1'b0, i_mem.busy);
			rd(a, d[0]);
		end
		// Page with a stray upper bit on one load
		a = {7'($urandom), 6'h00};
		for (int k = 0; k < 4; k++) begin
			d[k] = 8'($urandom);
			req(1'b1, k == 3, (k == 2 ? a ^ 13'h1000 : a) + 13'(k), d[k]);
		end
		wait_done(1'b0);
		chk1("memory idle", 1'b0, i_mem.busy);
		for (int k = 0; k < 4; k++)
			rd(a + 13'(k), d[k]);
		// Device slower than the timeout
		i_mem.wr_len = 1000;
		req(1'b1, 1'b1, a, 8'h5a);
		wait_done(1'b1);
		for (int i = 0; i < 2000 && i_mem.busy; i++)
			@(posedge CLK);
		if (i_mem.busy)
			stuck("memory");
		i_mem.wr_len = 100;
		rd(a, 8'h5a);
		chk1("pin protocol", 1'b1, i_mem.viol == 0);
		final_report();
	end
endmodule : eewr_host_tb_top

/* tb/eewr_mem_model.sv */
/*
 * Behavioural byte-wide EEPROM that answers the host controller.
 * Assumes the strobes are settled by the falling clock edge.
 */
module eewr_mem_model #(
	parameter int GAP = 40
) (
	// Clock
	input  wire logic        CLK,
	// Memory pins
	input  wire logic        CE_N,
	input  wire logic        OE_N,
	input  wire logic        WE_N,
	input  wire logic [12:0] ADDR,
	input  wire logic [7:0]  DQ_OUT,
	input  wire logic        DQ_OE,
	output logic [7:0]       DQ_IN
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:8191];
	logic [7:0] q       = 8'h00;
	logic [6:0] page    = 7'h00;
	logic       tog     = 1'b0;
	logic       rd_d    = 1'b0;
	int         wr_len  = 100;
	int         gap_cnt = 0;
	int         wr_cnt  = 0;
	int         viol    = 0;
	wire        busy    = (gap_cnt > 0) || (wr_cnt > 0);
	wire        rd      = !CE_N && !OE_N && WE_N;
	always @(negedge CLK) begin
		if (!CE_N && !WE_N && OE_N) begin
			if (wr_cnt > 0 || DQ_OE !== 1'b1)
				viol++;
			if (gap_cnt > 0 && ADDR[12:6] !== page)
				viol++;
			// Toggle start value drawn once per write, before any poll
			if (gap_cnt == 0)
				tog = 1'($urandom);
			page = ADDR[12:6];
			mem[ADDR] = DQ_OUT;
			gap_cnt = GAP;
		end else if (gap_cnt > 0) begin
			gap_cnt--;
			if (gap_cnt == 0)
				wr_cnt = wr_len;
		end else if (wr_cnt > 0)
			wr_cnt--;
		if (rd && !rd_d && busy)
			tog = !tog;
		rd_d = rd;
		// Released bus shows a changing pattern
		q <= rd ? (busy ? {mem[ADDR][7], tog, mem[ADDR][5:0]} : mem[ADDR])
			: ~q;
	end
	assign DQ_IN = q;
endmodule : eewr_mem_model
